// File: hw/sar_seq_pkg.sv
// constants and types shared by the conversion sequencer
package sar_seq_pkg;
	localparam int RESULT_BITS = 18;
	localparam logic [17:0] CODE_MAX = 18'h3FFFF;
	localparam logic [17:0] CODE_ZERO = 18'h00000;
	localparam logic [17:0] CODE_MID = 18'h20000;
	// reduced span has gain 0.8: codes above the offset are stretched by 5/4
	localparam int SPAN_NUM = 4;
	localparam int SPAN_DEN = 5;
	localparam logic [17:0] SPAN_OFFSET = 18'h06666;
	// switch settling: first switches open before the arrays move to ground
	localparam real SWITCH_SETTLE_NS = 8.0;
	localparam real CLK_PERIOD_NS = 4.0;
	// whole clock periods, rounded up; a plain real-to-int cast rounds to nearest
	localparam int SWITCH_SETTLE_CYC = int'($ceil(SWITCH_SETTLE_NS / CLK_PERIOD_NS));
	localparam logic [3:0] SETTLE_CYC = 4'(SWITCH_SETTLE_CYC);
	localparam logic [4:0] LAST_TRIAL = 5'h00;
	localparam logic [4:0] FIRST_TRIAL = 5'h11;

	typedef enum logic [2:0] {
		ST_ACQUIRE = 3'b000,
		ST_OPEN_SW = 3'b001,
		ST_GROUND = 3'b010,
		ST_TRIAL = 3'b011,
		ST_CODE = 3'b100
	} seq_state_t;
endpackage : sar_seq_pkg

// File: hw/sar_trial_if.sv
// carrier between sequencer and bit-trial register
`timescale 1ns/100ps
interface sar_trial_if;
	logic clear;
	logic step;
	logic [4:0] bit_index;
	logic keep_bit;
	logic [17:0] trial_code;
	modport ctrl (output clear, output step, output bit_index, output keep_bit, input trial_code);
	modport reg_side (input clear, input step, input bit_index, input keep_bit, output trial_code);
endinterface : sar_trial_if

// File: hw/sar_trial_reg.sv
// successive approximation register: one bit decided per step
`timescale 1ns/100ps
module sar_trial_reg (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// trial control
	sar_trial_if.reg_side tr
);
	typedef struct packed {
		logic [17:0] code;
	} trial_state_t;
	trial_state_t cur;
	trial_state_t nxt;

	always_comb begin
		nxt = cur;
		if (tr.clear) begin
			// msb tried first at half scale
			nxt.code = sar_seq_pkg::CODE_MID;
		end else if (tr.step) begin
			nxt.code[tr.bit_index] = tr.keep_bit;
			if (tr.bit_index != sar_seq_pkg::LAST_TRIAL) begin
				nxt.code[tr.bit_index - 5'h01] = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
		end else begin
			cur <= nxt;
		end
	end

	assign tr.trial_code = cur.code;
endmodule : sar_trial_reg

// File: hw/sar_conversion_sequencer.sv
// conversion sequencer: switches, bit trials, output coding, overvoltage flag
// Function
// - start input rising edge ends acquisition, starts conversion
// - open sampling switches, then ground arrays
// - eighteen trials, msb first, weights halving
// - after trials form code, signal via busy
// - timed by internal clock, no serial clock
// - straight binary, midscale 0x20000
// - over-range saturates to 0x3FFFF
// - under-range saturates to 0x00000
// - span compression maps reduced span fully
// - sticky overvoltage flag, cleared by read
// - overvoltage state in result status bits
// - span compression off after reset
`timescale 1ns/100ps
module sar_conversion_sequencer (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// conversion control pin
	input wire logic conversion_start_input,
	// analog front end
	output logic positive_sampling_switch,
	output logic negative_sampling_switch,
	output logic array_to_input,
	output logic [17:0] dac_code,
	input wire logic comparator_high,
	input wire logic clamp_active,
	// configuration and readback
	input wire logic span_compress_set,
	input wire logic span_compress_clear,
	input wire logic flag_read,
	output logic overvoltage_clamp_flag,
	output logic span_compress_on,
	// result
	output logic busy,
	output logic result_valid,
	output logic [17:0] result_code,
	output logic result_status_ov
);
	// every register of the sequencer except the trial code, which sits in u_trial
	typedef struct packed {
		logic [2:0] start_sync;
		logic start_seen;
		logic [2:0] clamp_sync;
		logic clamp_seen;
		sar_seq_pkg::seq_state_t state;
		logic [3:0] settle;
		logic [4:0] bit_index;
		logic sw_closed;
		logic arr_input;
		logic busy;
		logic valid;
		logic [17:0] result;
		logic status_ov;
		logic ov_flag;
		logic span_on;
		logic conv_ov;
	} seq_t;
	seq_t cur;
	seq_t next_cur;
	sar_trial_if tr ();
	logic start_level;
	logic clamp_level;
	logic start_rise;
	logic [17:0] span_diff;
	logic [20:0] scaled;
	logic [17:0] coded;

	sar_trial_reg u_trial (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tr(tr)
	);

	////////////////////////////////////////////////////////////////////////
	// synchronised pin levels: a change counts once stages two and three agree
	always_comb begin
		start_level = cur.start_seen;
		if (cur.start_sync[1] == cur.start_sync[2]) begin
			start_level = cur.start_sync[2];
		end
		clamp_level = cur.clamp_seen;
		if (cur.clamp_sync[1] == cur.clamp_sync[2]) begin
			clamp_level = cur.clamp_sync[2];
		end
		start_rise = start_level & ~cur.start_seen;
	end

	////////////////////////////////////////////////////////////////////////
	// span compression: 0.1..0.9 of the raw span is stretched onto the full code range
	always_comb begin
		span_diff = tr.trial_code - sar_seq_pkg::SPAN_OFFSET;
		scaled = 21'((22'(span_diff) * 22'(sar_seq_pkg::SPAN_DEN))
			/ 22'(sar_seq_pkg::SPAN_NUM));
		coded = scaled[17:0];
		if (tr.trial_code < sar_seq_pkg::SPAN_OFFSET) begin
			// below 0.1 of the reference
			coded = sar_seq_pkg::CODE_ZERO;
		end else if (scaled > 21'(sar_seq_pkg::CODE_MAX)) begin
			// above 0.9 of the reference
			coded = sar_seq_pkg::CODE_MAX;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		next_cur = cur;
		next_cur.start_sync = {cur.start_sync[1:0], conversion_start_input};
		next_cur.clamp_sync = {cur.clamp_sync[1:0], clamp_active};
		next_cur.start_seen = start_level;
		next_cur.clamp_seen = clamp_level;
		tr.clear = 1'b0;
		tr.step = 1'b0;
		tr.bit_index = cur.bit_index;
		tr.keep_bit = comparator_high;
		// span compression: set wins over clear, off from reset on
		if (span_compress_set) begin
			next_cur.span_on = 1'b1;
		end else if (span_compress_clear) begin
			next_cur.span_on = 1'b0;
		end
		// sticky flag: a new clamp event wins over the read clear
		if (clamp_level) begin
			next_cur.ov_flag = 1'b1;
		end else if (flag_read) begin
			next_cur.ov_flag = 1'b0;
		end
		// clamp seen at any point of the running conversion
		if (clamp_level) begin
			next_cur.conv_ov = 1'b1;
		end

		unique case (cur.state)
			sar_seq_pkg::ST_ACQUIRE: begin
				// arrays track the input until a start edge
				next_cur.valid = 1'b0;
				if (start_rise) begin
					next_cur.state = sar_seq_pkg::ST_OPEN_SW;
					next_cur.sw_closed = 1'b0;
					next_cur.busy = 1'b1;
					next_cur.settle = sar_seq_pkg::SETTLE_CYC;
					next_cur.conv_ov = clamp_level;
				end
			end
			sar_seq_pkg::ST_OPEN_SW: begin
				// comparator-side switches open, arrays still on the inputs
				next_cur.settle = cur.settle - 4'h1;
				if (cur.settle == 4'h1) begin
					next_cur.arr_input = 1'b0;
					next_cur.state = sar_seq_pkg::ST_GROUND;
					next_cur.settle = sar_seq_pkg::SETTLE_CYC;
				end
			end
			sar_seq_pkg::ST_GROUND: begin
				// arrays on ground; the msb trial is loaded on exit
				next_cur.settle = cur.settle - 4'h1;
				if (cur.settle == 4'h1) begin
					tr.clear = 1'b1;
					next_cur.bit_index = sar_seq_pkg::FIRST_TRIAL;
					next_cur.state = sar_seq_pkg::ST_TRIAL;
				end
			end
			sar_seq_pkg::ST_TRIAL: begin
				// one trial per internal clock edge, no serial clock involved
				tr.step = 1'b1;
				next_cur.bit_index = cur.bit_index - 5'h01;
				if (cur.bit_index == sar_seq_pkg::LAST_TRIAL) begin
					next_cur.state = sar_seq_pkg::ST_CODE;
				end
			end
			sar_seq_pkg::ST_CODE: begin
				// result latched, front end back to acquisition
				if (!cur.span_on) begin
					next_cur.result = tr.trial_code;
				end else begin
					next_cur.result = coded;
				end
				next_cur.status_ov = cur.conv_ov | clamp_level;
				next_cur.valid = 1'b1;
				next_cur.busy = 1'b0;
				next_cur.sw_closed = 1'b1;
				next_cur.arr_input = 1'b1;
				next_cur.state = sar_seq_pkg::ST_ACQUIRE;
			end
			default: begin
				next_cur.state = sar_seq_pkg::ST_ACQUIRE;
				next_cur.busy = 1'b0;
				next_cur.sw_closed = 1'b1;
				next_cur.arr_input = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '{
				state: sar_seq_pkg::ST_ACQUIRE,
				sw_closed: 1'b1,
				arr_input: 1'b1,
				result: sar_seq_pkg::CODE_ZERO,
				default: '0
			};
		end else begin
			cur <= next_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign positive_sampling_switch = cur.sw_closed;
	assign negative_sampling_switch = cur.sw_closed;
	assign array_to_input = cur.arr_input;
	assign dac_code = tr.trial_code;
	assign overvoltage_clamp_flag = cur.ov_flag;
	assign span_compress_on = cur.span_on;
	assign busy = cur.busy;
	assign result_valid = cur.valid;
	assign result_code = cur.result;
	assign result_status_ov = cur.status_ov;
endmodule : sar_conversion_sequencer

// File: test/sar_conversion_sequencer_assertions.sv
// port checker for the conversion sequencer
`timescale 1ns/100ps
module sar_seq_chk (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// observed ports
	input wire logic busy,
	input wire logic positive_sampling_switch,
	input wire logic negative_sampling_switch,
	input wire logic array_to_input,
	input wire logic [17:0] dac_code,
	input wire logic result_valid,
	input wire logic clamp_active,
	input wire logic flag_read,
	input wire logic overvoltage_clamp_flag,
	input wire logic span_compress_set,
	input wire logic span_compress_on
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence start_s; $rose(busy); endsequence
	sequence quiet_read_s; !clamp_active [*4] ##0 flag_read; endsequence
	chk_switch_open: assert property (start_s |-> !positive_sampling_switch && !negative_sampling_switch)
		else $error("switches closed at start");
	chk_array_ground: assert property (start_s |-> array_to_input ##2 !array_to_input)
		else $error("arrays not grounded after switches");
	chk_msb_first: assert property (start_s |-> ##4 dac_code == 18'h20000)
		else $error("first trial not msb");
	chk_conv_length: assert property (start_s |-> ##22 busy ##1 !busy)
		else $error("busy length wrong");
	chk_done_restore: assert property ($fell(busy) |-> result_valid && array_to_input)
		else $error("result not latched with busy fall");
	chk_span_set: assert property (span_compress_set |=> span_compress_on)
		else $error("span compression not on");
	chk_ov_hold: assert property (overvoltage_clamp_flag && !flag_read |=> overvoltage_clamp_flag)
		else $error("flag lost without read");
	chk_ov_clear: assert property (quiet_read_s |=> !overvoltage_clamp_flag)
		else $error("flag not cleared by read");
endmodule : sar_seq_chk
bind sar_conversion_sequencer sar_seq_chk sar_seq_chk_inst (.core_clk, .rst_n, .busy,
	.positive_sampling_switch, .negative_sampling_switch, .array_to_input, .dac_code,
	.result_valid, .clamp_active, .flag_read, .overvoltage_clamp_flag, .span_compress_set,
	.span_compress_on);

// File: test/sar_front_model.sv
// comparator model: held input level against the trial code
`timescale 1ns/100ps
module sar_front_model (
	// clock
	input wire logic core_clk,
	// sequencer side
	input wire logic busy,
	input wire logic [17:0] dac_code,
	output logic comparator_high,
	// bench side
	input wire logic [17:0] next_level
);
	logic [17:0] level = 18'h00000;
	// the channel only moves while no conversion runs
	always @(posedge core_clk) if (!busy) level <= next_level;
	assign comparator_high = (dac_code <= level);
endmodule : sar_front_model

// File: test/sar_conversion_sequencer_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module sar_conversion_sequencer_tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic conversion_start_input = 1'b0;
	logic clamp_active = 1'b0;
	logic span_compress_set = 1'b0;
	logic span_compress_clear = 1'b0;
	logic flag_read = 1'b0;
	logic comparator_high, positive_sampling_switch, negative_sampling_switch, array_to_input;
	logic overvoltage_clamp_flag, span_compress_on, busy, result_valid, result_status_ov;
	logic [17:0] dac_code, result_code;
	logic [17:0] level = 18'h00000;
	logic [17:0] lv[6] = '{18'h20000, 18'h20001, 18'h1FFFF, 18'h3FFFF, 18'h00000, 18'h01000};
	logic [18:0] expq[$];
	int num_errors = 0;
	int n_compared = 0;
	always #2 core_clk = ~core_clk;
	sar_conversion_sequencer sar_conversion_sequencer_inst (.core_clk, .rst_n,
		.conversion_start_input, .positive_sampling_switch, .negative_sampling_switch,
		.array_to_input, .dac_code, .comparator_high, .clamp_active, .span_compress_set,
		.span_compress_clear, .flag_read, .overvoltage_clamp_flag, .span_compress_on, .busy,
		.result_valid, .result_code, .result_status_ov);
	sar_front_model sar_front_model_inst (.core_clk, .busy, .dac_code, .comparator_high,
		.next_level(level));
	task summarize;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	task chk(string what, logic [18:0] e, logic [18:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task tick(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	task wait_busy(logic v);
		int i;
		for (i = 0; i < 100 && busy !== v; i++) tick(1);
		if (i == 100) begin
			num_errors++;
			summarize();
		end
	endtask : wait_busy
	// reduced span: 0.1 of full scale maps to zero, gain 5/4, saturating
	function automatic logic [17:0] spanned(logic [17:0] v);
		int t;
		t = (int'(v) - int'(sar_seq_pkg::SPAN_OFFSET)) * 5 / 4;
		return t < 0 ? 18'h00000 : t > 'h3FFFF ? 18'h3FFFF : 18'(t);
	endfunction : spanned
	task convert(logic [17:0] v, logic ov, logic [17:0] e);
		level = v;
		clamp_active = ov;
		expq.push_back({ov, e});
		conversion_start_input = 1'b1;
		wait_busy(1'b1);
		wait_busy(1'b0);
		conversion_start_input = 1'b0;
		clamp_active = 1'b0;
		tick(2);
	endtask : convert
	always @(negedge busy) if (rst_n) begin
		#1;
		if (expq.size() == 0) chk("spare result", 19'h00000, 19'h7FFFF);
		else chk("result", expq.pop_front(), {result_status_ov, result_code});
	end
	initial begin
		logic [17:0] r;
		void'($urandom(36));
		repeat (10) @(posedge core_clk);
		#1 rst_n = 1'b1;
		tick(2);
		chk("span after reset", 19'h00000, {18'h00000, span_compress_on});
		foreach (lv[i]) convert(lv[i], 1'b0, lv[i]);
		repeat (6) begin
			r = 18'($urandom);
			convert(r, 1'b0, r);
		end
		convert(18'h00123, 1'b1, 18'h00123);
		tick(3);
		chk("flag set", 19'h00001, {18'h00000, overvoltage_clamp_flag});
		flag_read = 1'b1;
		tick(1);
		flag_read = 1'b0;
		chk("flag read", 19'h00000, {18'h00000, overvoltage_clamp_flag});
		span_compress_set = 1'b1;
		tick(1);
		span_compress_set = 1'b0;
		chk("span on", 19'h00001, {18'h00000, span_compress_on});
		foreach (lv[i]) convert(lv[i], 1'b0, spanned(lv[i]));
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		tick(2);
		chk("span after second reset", 19'h00000, {18'h00000, span_compress_on});
		span_compress_set = 1'b1;
		tick(1);
		span_compress_set = 1'b0;
		span_compress_clear = 1'b1;
		tick(1);
		span_compress_clear = 1'b0;
		convert(18'h00040, 1'b0, 18'h00040);
		summarize();
	end
endmodule : sar_conversion_sequencer_tb
